// ==== ieps_cfg_store.sv ====
/*
  constants shared by the integrated endpoint configuration block, and
  the word storage used for one function's configuration space.
  assumes one clock mclk and an active-low asynchronous reset rstn.
*/
`timescale 1ns/1ns

// ==========================================================
// constants
package ieps_pkg;
  localparam int CFG_WORDS = 56;
  localparam logic [5:0] EXT_BASE_IDX = 6'h24;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] ABSENT_DATA = 32'hFFFF_FFFF;
  localparam logic [2:0] WORD_SIZE = 3'h2;
  localparam logic [7:0] ROOT_BUS = 8'h00;
  localparam logic [11:0] OFF_ID = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  localparam logic [11:0] OFF_CLASS = 12'h008;
  localparam logic [11:0] OFF_HDR = 12'h00C;
  localparam logic [11:0] OFF_BAR0 = 12'h010;
  localparam logic [11:0] OFF_RP_BUS = 12'h018;
  localparam logic [11:0] OFF_RP_IO = 12'h01C;
  localparam logic [11:0] OFF_RP_MEM = 12'h020;
  localparam logic [11:0] OFF_RP_PMEM = 12'h024;
  localparam logic [11:0] OFF_RP_PMBU = 12'h028;
  localparam logic [11:0] OFF_RP_PMLU = 12'h02C;
  localparam logic [11:0] OFF_EP_SUBSYS = 12'h02C;
  localparam logic [11:0] OFF_RP_IOU = 12'h030;
  localparam logic [11:0] OFF_CAPP = 12'h034;
  localparam logic [11:0] OFF_INT = 12'h03C;
  localparam logic [11:0] OFF_PM = 12'h040;
  localparam logic [11:0] OFF_PMCSR = 12'h044;
  localparam logic [11:0] OFF_PCIE = 12'h050;
  localparam logic [11:0] OFF_DEVCAP = 12'h054;
  localparam logic [11:0] OFF_DEVCTL = 12'h058;
  localparam logic [11:0] OFF_LNKCAP = 12'h05C;
  localparam logic [11:0] OFF_LNKCTL = 12'h060;
  localparam logic [11:0] OFF_SLTCTL = 12'h068;
  localparam logic [11:0] OFF_ROOTCTL = 12'h06C;
  localparam logic [11:0] OFF_DEVCTL2 = 12'h078;
  localparam logic [11:0] OFF_LNKCAP2 = 12'h07C;
  localparam logic [11:0] OFF_LNKCTL2 = 12'h080;
  localparam logic [11:0] OFF_SEC = 12'h100;
  localparam logic [11:0] OFF_LNKCTL3 = 12'h104;
  localparam logic [11:0] OFF_LANEEQ = 12'h10C;
  localparam logic [11:0] OFF_DLF = 12'h110;
  localparam logic [11:0] OFF_DLFCAP = 12'h114;
  localparam logic [11:0] OFF_PL16 = 12'h120;
  localparam logic [11:0] OFF_MARG = 12'h140;
  localparam logic [11:0] OFF_MARGLANE = 12'h148;
  localparam logic [11:0] OFF_NONE = 12'h000;
  localparam int BIT_BME = 2;
  localparam int BIT_LDIS = 4;
  localparam int BIT_FLR = 15;
  localparam int BIT_SBR = 22;
  localparam int BIT_DLLSC = 24;
  localparam int BIT_DLLACT = 29;
  localparam logic [7:0] CAPID_PM = 8'h01;
  localparam logic [7:0] CAPID_PCIE = 8'h10;
  localparam logic [15:0] ECAP_SEC = 16'h0019;
  localparam logic [15:0] ECAP_DLF = 16'h0025;
  localparam logic [15:0] ECAP_PL16 = 16'h0026;
  localparam logic [15:0] ECAP_MARG = 16'h0027;
  localparam logic [3:0] ECAP_VER = 4'h1;
  localparam logic [3:0] PCIE_CAP_VER = 4'h2;
  localparam logic [3:0] TYPE_EP = 4'h0;
  localparam logic [3:0] TYPE_RP = 4'h4;
  localparam logic [7:0] HDR_TYPE0 = 8'h00;
  localparam logic [7:0] HDR_TYPE1 = 8'h01;
  localparam logic [15:0] PMC_VAL = 16'h0003;
  localparam logic [23:0] CLASS_BRIDGE = 24'h06_0400;
  localparam logic [3:0] SPEED_8G = 4'h3;
  localparam logic [3:0] SPEED_16G = 4'h4;

  typedef enum logic {ST_IDLE = 1'b0, ST_DATA = 1'b1} ieps_state_t;

  // storage index of a configuration offset
  function automatic logic [5:0] cfg_idx(input logic [11:0] off);
    return off[8] ? 6'(EXT_BASE_IDX + {1'b0, off[6:2]}) : off[7:2];
  endfunction
endpackage

// ==========================================================
// word storage with bit write masks
module ieps_cfg_store
  import ieps_pkg::*;
#(
  parameter int WORDS = CFG_WORDS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] wr_mask,
  output logic [31:0] words [WORDS]
);
  logic [31:0] store [WORDS];
  logic [31:0] next_store [WORDS];

  always_comb begin
    next_store = store;
    if (clr) begin
      for (int i = 0; i < WORDS; i++) begin
        next_store[i] = CFG_RST;
      end
    end else if (wr_en && int'(wr_idx) < WORDS) begin
      next_store[wr_idx] = (store[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < WORDS; i++) begin
        store[i] <= CFG_RST;
      end
    end else begin
      store <= next_store;
    end
  end

  assign words = store;
endmodule

// ==== ieps_top.sv ====
/*
  configuration space of an on-chip peripheral shown to software as an
  endpoint behind its own root port, reached through an ecam window on
  an ahb-lite slave port.
  assumes one clock mclk, reset rstn, a single ahb-lite master issuing
  single word transfers, and memory requests from the peripheral logic
  on the same clock.
*/
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns

// Operation
// - endpoint exposes the full type 0 header
// - endpoint exposes the pci express capability with device and link regs
// - root port exposes the full type 1 bridge header
// - root port keeps upper prefetchable and upper io window extensions
// - root port capability adds slot and root registers
// - both functions expose the power management capability
// - speeds of 8gt/s and up add the secondary extended capability
// - speeds of 16gt/s and up add the data link feature capability
// - speeds of 16gt/s and up add the 16gt/s physical layer capability
// - speeds of 16gt/s and up add the lane margining capability
// - accesses inside the ecam window are handled as config requests
// - secondary bus reset on the root port hot-resets the endpoint
// - endpoint issues no memory requests while bus master is disabled
module ieps_top
  import ieps_pkg::*;
#(
  parameter logic [31:0] ECAM_BASE = 32'h4000_0000,
  parameter logic [3:0] MAX_SPEED = 4'h4,
  parameter logic [15:0] VENDOR_ID = 16'h1234,  // arbitrary value
  parameter logic [15:0] RP_DEV_ID = 16'h0001,  // arbitrary value
  parameter logic [15:0] EP_DEV_ID = 16'h0002,  // arbitrary value
  parameter logic [15:0] SUBSYS_ID = 16'h0003,  // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01,  // arbitrary value
  parameter logic [23:0] EP_CLASS = 24'hFF_0000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ep_mem_req,
  output logic ep_mem_out,
  output logic ep_hot_reset,
  output logic [7:0] ep_bus_num
);
  localparam logic SEC_ON = MAX_SPEED >= SPEED_8G;
  localparam logic HI_ON = MAX_SPEED >= SPEED_16G;
  localparam logic [7:0] SPEED_VEC =
    8'((9'h001 << (MAX_SPEED + 4'h1)) - 9'h002);

  // ==========================================================
  // field functions
  function automatic logic [31:0] ext_hdr(input logic [11:0] nxt,
                                          input logic [15:0] id);
    return {nxt, ECAP_VER, id};
  endfunction

  // fixed bits of a word
  function automatic logic [31:0] ro_val(input logic rp,
                                         input logic [11:0] off);
    logic [31:0] v;
    v = CFG_RST;
    if (off == OFF_ID) begin
      v = {rp ? RP_DEV_ID : EP_DEV_ID, VENDOR_ID};
    end else if (off == OFF_CLASS) begin
      v = {rp ? CLASS_BRIDGE : EP_CLASS, REV_ID};
    end else if (off == OFF_HDR) begin
      v = {8'h00, rp ? HDR_TYPE1 : HDR_TYPE0, 16'h0000};
    end else if (off == OFF_CAPP) begin
      v = {24'h00_0000, OFF_PM[7:0]};
    end else if (off == OFF_PM) begin
      v = {PMC_VAL, OFF_PCIE[7:0], CAPID_PM};
    end else if (off == OFF_PCIE) begin
      v = {8'h00, rp ? TYPE_RP : TYPE_EP, PCIE_CAP_VER, 8'h00,
           CAPID_PCIE};
    end else if (off == OFF_DEVCAP) begin
      v = {3'h0, ~rp, 12'h000, 16'h8020};
    end else if (off == OFF_LNKCAP) begin
      v = {11'h000, rp, 10'h000, 6'h01, MAX_SPEED};
    end else if (off == OFF_LNKCTL) begin
      v = {6'h00, 6'h01, MAX_SPEED, 16'h0000};
    end else if (off == OFF_LNKCAP2) begin
      v = {24'h00_0000, SPEED_VEC};
    end else if (!rp && off == OFF_EP_SUBSYS) begin
      v = {SUBSYS_ID, VENDOR_ID};
    end else if (rp && off == OFF_SLTCTL) begin
      v = 32'h0040_0000;
    end else if (rp && off == OFF_RP_IO) begin
      v = 32'h0000_0101;
    end else if (rp && off == OFF_RP_PMEM) begin
      v = 32'h0001_0001;
    end else if (SEC_ON && off == OFF_SEC) begin
      v = ext_hdr(HI_ON ? OFF_DLF : OFF_NONE, ECAP_SEC);
    end else if (HI_ON && off == OFF_DLF) begin
      v = ext_hdr(OFF_PL16, ECAP_DLF);
    end else if (HI_ON && off == OFF_DLFCAP) begin
      v = 32'h0000_0001;
    end else if (HI_ON && off == OFF_PL16) begin
      v = ext_hdr(OFF_MARG, ECAP_PL16);
    end else if (HI_ON && off == OFF_MARG) begin
      v = ext_hdr(OFF_NONE, ECAP_MARG);
    end
    return v;
  endfunction

  // writable bits of a word
  function automatic logic [31:0] wr_mask(input logic rp,
                                          input logic [11:0] off);
    logic [31:0] m;
    m = CFG_RST;
    if (off == OFF_CMD) begin
      m = 32'h0000_0546;
    end else if (off == OFF_HDR) begin
      m = 32'h0000_00FF;
    end else if (off == OFF_BAR0) begin
      m = 32'hFFFF_F000;
    end else if (off == OFF_INT) begin
      m = rp ? 32'h004F_00FF : 32'h0000_00FF;
    end else if (off == OFF_PMCSR) begin
      m = 32'h0000_0103;
    end else if (off == OFF_DEVCTL) begin
      m = 32'h0000_79FF;
    end else if (off == OFF_LNKCTL) begin
      m = rp ? 32'h0000_00DB : 32'h0000_00CB;
    end else if (off == OFF_DEVCTL2) begin
      m = 32'h0000_001F;
    end else if (off == OFF_LNKCTL2) begin
      m = 32'h0000_000F;
    end else if (rp && off == OFF_RP_BUS) begin
      m = 32'hFFFF_FFFF;
    end else if (rp && off == OFF_RP_IO) begin
      m = 32'h0000_F0F0;
    end else if (rp && (off == OFF_RP_MEM || off == OFF_RP_PMEM)) begin
      m = 32'hFFF0_FFF0;
    end else if (rp && (off == OFF_RP_PMBU || off == OFF_RP_PMLU ||
                        off == OFF_RP_IOU)) begin
      m = 32'hFFFF_FFFF;
    end else if (rp && off == OFF_SLTCTL) begin
      m = 32'h0000_1000;
    end else if (rp && off == OFF_ROOTCTL) begin
      m = 32'h0000_001F;
    end else if (SEC_ON && off == OFF_LNKCTL3) begin
      m = 32'h0000_0003;
    end else if (SEC_ON && off == OFF_LANEEQ) begin
      m = 32'h0000_7F7F;
    end else if (HI_ON && off == OFF_DLFCAP) begin
      m = 32'h8000_0000;
    end else if (HI_ON && off == OFF_MARGLANE) begin
      m = 32'h0000_FFFF;
    end
    return m;
  endfunction

  // ==========================================================
  // storage
  logic [31:0] rp_w [CFG_WORDS];
  logic [31:0] ep_w [CFG_WORDS];
  ieps_state_t state, next_state;
  logic next_ready;
  logic [31:0] next_rdata;
  logic a_wr, a_win, a_rp, a_ep;
  logic next_a_wr, next_a_win, next_a_rp, next_a_ep;
  logic [11:0] a_off, next_a_off;
  logic [7:0] a_bus, next_a_bus;
  logic ep_flr, next_flr, next_hot, next_mem_out;
  logic link_up, next_link_up, dllsc, next_dllsc;
  logic [7:0] next_bus_num;
  logic take, in_win, hit_rp, hit_ep, wr_rp, wr_ep, ep_clr;
  logic sbr, ldis, bme, rd_fn;
  logic [7:0] sec_bus, sub_bus;
  logic [31:0] rd_val;

  assign sbr = rp_w[cfg_idx(OFF_INT)][BIT_SBR];
  assign ldis = rp_w[cfg_idx(OFF_LNKCTL)][BIT_LDIS];
  assign bme = ep_w[cfg_idx(OFF_CMD)][BIT_BME];
  assign sec_bus = rp_w[cfg_idx(OFF_RP_BUS)][15:8];
  assign sub_bus = rp_w[cfg_idx(OFF_RP_BUS)][23:16];
  assign wr_rp = state == ST_DATA && a_wr && a_rp;
  assign wr_ep = state == ST_DATA && a_wr && a_ep;
  assign ep_clr = ep_hot_reset | ep_flr;
  assign rd_fn = state == ST_DATA && !a_wr && (a_rp || a_ep);

  ieps_cfg_store #(.WORDS(CFG_WORDS)) u_rp (
    .mclk(mclk),
    .rstn(rstn),
    .clr(1'b0),
    .wr_en(wr_rp),
    .wr_idx(cfg_idx(a_off)),
    .wr_data(hwdata),
    .wr_mask(wr_mask(1'b1, a_off)),
    .words(rp_w)
  );

  ieps_cfg_store #(.WORDS(CFG_WORDS)) u_ep (
    .mclk(mclk),
    .rstn(rstn),
    .clr(ep_clr),
    .wr_en(wr_ep),
    .wr_idx(cfg_idx(a_off)),
    .wr_data(hwdata),
    .wr_mask(wr_mask(1'b0, a_off)),
    .words(ep_w)
  );

  // ==========================================================
  // ecam decode and bus slave
  always_comb begin
    take = hsel && hready && htrans[1] && hsize == WORD_SIZE;
    in_win = haddr[31:28] == ECAM_BASE[31:28];
    hit_rp = in_win && haddr[27:20] == ROOT_BUS && haddr[19:12] == 8'h00;
    hit_ep = in_win && haddr[27:20] == sec_bus && sec_bus != ROOT_BUS &&
             haddr[27:20] <= sub_bus && haddr[19:12] == 8'h00 &&
             !ep_hot_reset;
    rd_val = CFG_RST;
    if (a_rp) begin
      rd_val = (rp_w[cfg_idx(a_off)] & wr_mask(1'b1, a_off)) |
               ro_val(1'b1, a_off);
      if (a_off == OFF_SLTCTL) begin
        rd_val[BIT_DLLSC] = dllsc;
      end
      if (a_off == OFF_LNKCTL) begin
        rd_val[BIT_DLLACT] = link_up;
      end
    end else if (a_ep) begin
      rd_val = (ep_w[cfg_idx(a_off)] & wr_mask(1'b0, a_off)) |
               ro_val(1'b0, a_off);
    end else if (a_win) begin
      rd_val = ABSENT_DATA;
    end
    next_state = state;
    next_ready = hreadyout;
    next_rdata = hrdata;
    next_a_wr = a_wr;
    next_a_win = a_win;
    next_a_rp = a_rp;
    next_a_ep = a_ep;
    next_a_off = a_off;
    next_a_bus = a_bus;
    if (state == ST_IDLE) begin
      if (take) begin
        next_state = ST_DATA;
        next_ready = 1'b0;
        next_a_wr = hwrite;
        next_a_win = in_win;
        next_a_rp = hit_rp;
        next_a_ep = hit_ep;
        next_a_off = {haddr[11:2], 2'b00};
        next_a_bus = haddr[27:20];
      end
    end else begin
      next_state = ST_IDLE;
      next_ready = 1'b1;
      next_rdata = a_wr ? CFG_RST : rd_val;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      hreadyout <= 1'b1;
      hrdata <= CFG_RST;
      hresp <= 1'b0;
      a_wr <= 1'b0;
      a_win <= 1'b0;
      a_rp <= 1'b0;
      a_ep <= 1'b0;
      a_off <= OFF_NONE;
      a_bus <= ROOT_BUS;
    end else begin
      state <= next_state;
      hreadyout <= next_ready;
      hrdata <= next_rdata;
      hresp <= 1'b0;
      a_wr <= next_a_wr;
      a_win <= next_a_win;
      a_rp <= next_a_rp;
      a_ep <= next_a_ep;
      a_off <= next_a_off;
      a_bus <= next_a_bus;
    end
  end

  // ==========================================================
  // endpoint control and link events
  always_comb begin
    next_hot = sbr | ldis;
    next_flr = wr_ep && a_off == OFF_DEVCTL && hwdata[BIT_FLR];
    next_mem_out = ep_mem_req && bme && !ep_hot_reset;
    next_bus_num = ep_clr ? ROOT_BUS : (wr_ep ? a_bus : ep_bus_num);
    next_link_up = !ldis;
    // a change of link state wins over a clear in the same cycle
    next_dllsc = (link_up != next_link_up) ||
                 (dllsc && !(wr_rp && a_off == OFF_SLTCTL &&
                             hwdata[BIT_DLLSC]));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ep_hot_reset <= 1'b0;
      ep_flr <= 1'b0;
      ep_mem_out <= 1'b0;
      ep_bus_num <= ROOT_BUS;
      link_up <= 1'b1;
      dllsc <= 1'b0;
    end else begin
      ep_hot_reset <= next_hot;
      ep_flr <= next_flr;
      ep_mem_out <= next_mem_out;
      ep_bus_num <= next_bus_num;
      link_up <= next_link_up;
      dllsc <= next_dllsc;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_sbr_hot;
    sbr |=> ep_hot_reset;
  endproperty
  a_sbr_hot: assert property (p_sbr_hot)
    else $error("bus reset did not hot-reset endpoint");

  property p_bme_gate;
    !bme |=> !ep_mem_out;
  endproperty
  a_bme_gate: assert property (p_bme_gate)
    else $error("memory request with bus master off");

  property p_take_wait;
    (state == ST_IDLE && take) |=> !hreadyout ##1 (hreadyout && !hresp);
  endproperty
  a_take_wait: assert property (p_take_wait)
    else $error("config access not answered in two cycles");

  property p_rp_hdr;
    (rd_fn && a_rp && a_off == OFF_HDR) |=> hrdata[23:16] == HDR_TYPE1;
  endproperty
  a_rp_hdr: assert property (p_rp_hdr)
    else $error("root port header type wrong");

  property p_ep_hdr;
    (rd_fn && a_ep && a_off == OFF_HDR) |=> hrdata[23:16] == HDR_TYPE0;
  endproperty
  a_ep_hdr: assert property (p_ep_hdr)
    else $error("endpoint header type wrong");

  property p_ep_pcie;
    (rd_fn && a_ep && a_off == OFF_PCIE) |=>
      hrdata[7:0] == CAPID_PCIE && hrdata[23:20] == TYPE_EP;
  endproperty
  a_ep_pcie: assert property (p_ep_pcie)
    else $error("endpoint express capability wrong");

  property p_rp_pcie;
    (rd_fn && a_rp && a_off == OFF_PCIE) |=>
      hrdata[7:0] == CAPID_PCIE && hrdata[23:20] == TYPE_RP;
  endproperty
  a_rp_pcie: assert property (p_rp_pcie)
    else $error("root port express capability wrong");

  property p_pm;
    (rd_fn && a_off == OFF_PM) |=>
      hrdata[15:0] == {OFF_PCIE[7:0], CAPID_PM};
  endproperty
  a_pm: assert property (p_pm)
    else $error("power management capability wrong");

  property p_sec;
    (rd_fn && a_off == OFF_SEC) |=>
      hrdata[15:0] == (SEC_ON ? ECAP_SEC : 16'h0000);
  endproperty
  a_sec: assert property (p_sec)
    else $error("secondary extended capability wrong");

  property p_chain;
    (rd_fn && a_off == OFF_SEC) |=>
      hrdata[31:20] == (HI_ON ? OFF_DLF : OFF_NONE);
  endproperty
  a_chain: assert property (p_chain)
    else $error("extended capability chain wrong");

  property p_ecap(logic [11:0] o, logic [15:0] id);
    (rd_fn && a_off == o) |=> hrdata[15:0] == (HI_ON ? id : 16'h0000);
  endproperty
  a_dlf: assert property (p_ecap(OFF_DLF, ECAP_DLF))
    else $error("data link feature capability wrong");
  a_pl16: assert property (p_ecap(OFF_PL16, ECAP_PL16))
    else $error("physical layer capability wrong");
  a_marg: assert property (p_ecap(OFF_MARG, ECAP_MARG))
    else $error("lane margining capability wrong");

  property p_pmbu;
    (wr_rp && a_off == OFF_RP_PMBU) |=>
      rp_w[cfg_idx(OFF_RP_PMBU)] == $past(hwdata);
  endproperty
  a_pmbu: assert property (p_pmbu)
    else $error("upper prefetchable base not stored");

  c_ep_read: cover property (rd_fn && a_ep);
  c_hot: cover property (!ep_hot_reset ##1 ep_hot_reset);
  c_flr: cover property (ep_flr);
endmodule

// ==== ieps_ahb_master.sv ====
/*
  processor side model: an ahb-lite master that issues single word
  configuration reads and writes with a chosen number of idle cycles.
  assumes hready is the one slave's hreadyout, clock mclk.
*/
`timescale 1ns/1ns

// ==========================================================
// master model
module ieps_ahb_master (
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // one transfer; hsel and htrans drop to idle, released haddr and hwdata carry inverted values
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] wd, input int gap, output logic [31:0] rd);
    repeat (gap + 1) @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule

// ==== test_integrated_endpoint_config_space.sv ====
/*
  self-checking bench: random and corner configuration traffic.
  assumes the package constants and a max speed of 16gt/s.
*/
`timescale 1ns/1ns

// ==========================================================
// bench top
module test_integrated_endpoint_config_space
  import ieps_pkg::*;
();
  localparam logic [31:0] ECAM = 32'h4000_0000;
  logic mclk;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic ep_mem_req;
  logic ep_mem_out;
  logic ep_hot_reset;
  logic [7:0] ep_bus_num;
  logic [31:0] seed = 32'h0000_9f79;
  logic [31:0] rd;
  logic [31:0] v;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [11:0] eo [4] = '{OFF_SEC, OFF_DLF, OFF_PL16, OFF_MARG};
  logic [15:0] ei [4] = '{ECAP_SEC, ECAP_DLF, ECAP_PL16, ECAP_MARG};
  logic [11:0] uo [3] = '{OFF_RP_PMBU, OFF_RP_PMLU, OFF_RP_IOU};
  logic [11:0] so [2] = '{OFF_INT, OFF_LNKCTL};
  logic [31:0] sv [2] = '{32'h1 << BIT_SBR, 32'h1 << BIT_LDIS};

  ieps_top #(.ECAM_BASE(ECAM), .MAX_SPEED(SPEED_16G)) ieps_top_inst (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ep_mem_req(ep_mem_req), .ep_mem_out(ep_mem_out),
    .ep_hot_reset(ep_hot_reset), .ep_bus_num(ep_bus_num));

  ieps_ahb_master ieps_ahb_master_inst (.mclk(mclk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ca(input logic [7:0] bus,
      input logic [11:0] off);
    return ECAM | {4'h0, bus, 8'h00, off};
  endfunction

  task automatic rw(input logic w, input logic [7:0] bus,
      input logic [11:0] off, input logic [31:0] wd);
    ieps_ahb_master_inst.xfer(w, ca(bus, off), wd, int'(xs() % 3), rd);
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // random requests; output must follow one cycle later when enabled
  task automatic mem_run(input logic en);
    logic prev;
    logic [31:0] r;
    prev = ep_mem_req;
    repeat (12) begin
      r = xs();
      @(posedge mclk);
      ep_mem_req <= r[0];
      @(negedge mclk);
      chk("ep_mem_out", {31'h0, prev & en}, {31'h0, ep_mem_out});
      prev = r[0];
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // about 350 cycles of traffic expected
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    rstn = 1'b0;
    ep_mem_req = 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    ieps_ahb_master_inst.xfer(1'b0, 32'h5000_000C, 32'h0, 0, rd);
    chk("outside window", 32'h0, rd);
    rw(1'b1, ROOT_BUS, OFF_RP_BUS, 32'h0001_0100);
    rw(1'b0, ROOT_BUS, OFF_RP_BUS, 32'h0);
    chk("bus numbers", 32'h0001_0100, rd & 32'h00FF_FF00);
    ieps_ahb_master_inst.xfer(1'b0, ca(8'h00, OFF_ID) | 32'h8000, 0, 1, rd);
    chk("absent device", ABSENT_DATA, rd);
    rw(1'b0, 8'h02, OFF_ID, 32'h0);
    chk("absent bus", ABSENT_DATA, rd);
    for (int b = 0; b < 2; b++) begin
      rw(1'b0, 8'(b), OFF_HDR, 32'h0);
      v = {24'h0, b ? HDR_TYPE0 : HDR_TYPE1};
      chk("header type", v, {24'h0, rd[23:16]});
      rw(1'b0, 8'(b), OFF_CAPP, 32'h0);
      chk("cap pointer", {24'h0, OFF_PM[7:0]}, rd & 32'hFF);
      rw(1'b0, 8'(b), OFF_PM, 32'h0);
      chk("pm cap", {PMC_VAL, OFF_PCIE[7:0], CAPID_PM}, rd);
      rw(1'b0, 8'(b), OFF_PCIE, 32'h0);
      v = {8'h0, b ? TYPE_EP : TYPE_RP, PCIE_CAP_VER, 8'h0, CAPID_PCIE};
      chk("express cap", v, rd & 32'h00FF_00FF);
      rw(1'b0, 8'(b), OFF_LNKCAP2, 32'h0);
      chk("speeds", 32'h0000_001E, rd & 32'h0000_00FE);
      for (int i = 0; i < 4; i++) begin
        rw(1'b0, 8'(b), eo[i], 32'h0);
        v = {(i < 3) ? eo[i + 1] : 12'h000, ECAP_VER, ei[i]};
        chk("ext header", v, rd);
      end
      repeat (3) begin
        v = xs();
        rw(1'b1, 8'(b), OFF_BAR0, v);
        rw(1'b0, 8'(b), OFF_BAR0, 32'h0);
        chk("bar0", v & 32'hFFFF_F000, rd);
      end
    end
    chk("bus capture", 32'h1, {24'h0, ep_bus_num});
    for (int i = 0; i < 3; i++) begin
      v = xs();
      rw(1'b1, ROOT_BUS, uo[i], v);
      rw(1'b0, ROOT_BUS, uo[i], 32'h0);
      chk("upper window", v, rd);
    end
    mem_run(1'b0);
    rw(1'b1, 8'h01, OFF_CMD, 32'h1 << BIT_BME);
    mem_run(1'b1);
    for (int i = 0; i < 2; i++) begin
      rw(1'b1, ROOT_BUS, so[i], sv[i]);
      @(negedge mclk);
      chk("hot reset", 32'h1, {31'h0, ep_hot_reset});
      mem_run(1'b0);
      rw(1'b0, 8'h01, OFF_ID, 32'h0);
      chk("ep in reset", ABSENT_DATA, rd);
      rw(1'b1, ROOT_BUS, so[i], 32'h0);
      @(negedge mclk);
      chk("reset release", 32'h0, {31'h0, ep_hot_reset});
      rw(1'b0, 8'h01, OFF_CMD, 32'h0);
      chk("ep cmd cleared", 32'h0, rd);
      rw(1'b1, 8'h01, OFF_CMD, 32'h1 << BIT_BME);
    end
    rw(1'b0, ROOT_BUS, OFF_SLTCTL, 32'h0);
    chk("link changed", 32'h0140_0000, rd);
    rw(1'b1, ROOT_BUS, OFF_SLTCTL, 32'h1 << BIT_DLLSC);
    rw(1'b0, ROOT_BUS, OFF_SLTCTL, 32'h0);
    chk("link change cleared", 32'h0040_0000, rd);
    rw(1'b0, ROOT_BUS, OFF_LNKCTL, 32'h0);
    chk("link active", 32'h2014_0000, rd);
    rw(1'b1, 8'h01, OFF_DEVCTL, 32'h1 << BIT_FLR);
    rw(1'b0, 8'h01, OFF_CMD, 32'h0);
    chk("flr clears cmd", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    tally_and_finish();
  end
endmodule
